// >>> hw/mbsrc_checker.sv
`timescale 1ns/1ps
module mbsrc_checker #(
    parameter int NUM_REL = mbsrc_pkg::NUM_REL_MAX,
    parameter int IDX_W   = 5
) (
    input  wire logic                                          clk_i,
    input  wire logic                                          rst_i,
    input  wire logic [7:0]                                    own_addr_i,
    input  wire logic                                          cpu_stop_i,
    input  wire logic                                          bkpt_halt_i,
    input  wire logic                                          general_disable_i,
    input  wire logic [NUM_REL-1:0]                            disable_vec_i,
    input  wire mbsrc_pkg::mbsrc_dtype_t [NUM_REL-1:0]         rel_type_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::ADDR_W-1:0]     rel_start_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::ADDR_W-1:0]     rel_size_i,
    input  wire logic [NUM_REL-1:0]                            rel_ro_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::IEC_W-1:0]      rel_iec_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::IP_W-1:0]       filt_net_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::IP_W-1:0]       filt_mask_i,
    input  wire logic                                          req_valid_i,
    output logic                                               req_ready_o,
    input  wire logic [7:0]                                    req_slave_i,
    input  wire logic [7:0]                                    req_fc_i,
    input  wire logic [15:0]                                   req_addr_i,
    input  wire logic [mbsrc_pkg::QTY_W-1:0]                   req_qty_i,
    input  wire logic [15:0]                                   req_waddr_i,
    input  wire logic [mbsrc_pkg::QTY_W-1:0]                   req_wqty_i,
    input  wire logic                                          req_ip_check_i,
    input  wire logic [mbsrc_pkg::IP_W-1:0]                    req_ip_i,
    output logic                                               resp_valid_o,
    output logic                                               resp_reply_o,
    output logic                                               resp_serve_o,
    output logic [7:0]                                         resp_exc_o,
    output logic                                               resp_write_o,
    output logic                                               resp_is_bit_o,
    output logic [IDX_W-1:0]                                   resp_rel_o,
    output logic [IDX_W-1:0]                                   resp_wrel_o,
    output logic [mbsrc_pkg::IEC_W-1:0]                        resp_addr_o,
    output logic [mbsrc_pkg::IEC_W-1:0]                        resp_waddr_o,
    output logic [mbsrc_pkg::QTY_W-1:0]                        resp_qty_o
);
    import mbsrc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_HOLD, ST_RESP} mbsrc_state_t;

    mbsrc_state_t      state, next_state;
    logic [7:0]        q_slave, q_fc, next_q_slave, next_q_fc;
    logic [15:0]       q_addr, q_waddr, next_q_addr, next_q_waddr;
    logic [QTY_W-1:0]  q_qty, q_wqty, next_q_qty, next_q_wqty;
    logic              q_ipchk, next_q_ipchk;
    logic [IP_W-1:0]   q_ip, next_q_ip;
    logic              r_reply, r_serve, r_write, r_bit;
    logic              next_r_reply, next_r_serve, next_r_write, next_r_bit;
    logic [7:0]        r_exc, next_r_exc;
    logic [IDX_W-1:0]  r_rel, r_wrel, next_r_rel, next_r_wrel;
    logic [IEC_W-1:0]  r_addr, r_waddr, next_r_addr, next_r_waddr;
    logic [QTY_W-1:0]  r_qty, next_r_qty;

    logic              take, is_rw, is_wr, bcast, addr_ok, found_a, found_b;
    logic [IDX_W-1:0]  idx_a, idx_b;
    logic [ADDR_W-1:0] first_a, first_b;
    logic [QTY_W-1:0]  qty_a, qty_b;
    mbsrc_dtype_t      req_type;
    logic [7:0]        exc;

    function automatic logic blocked(input logic [IDX_W-1:0] idx);
        logic ip_ok;
        ip_ok = !q_ipchk || (((q_ip ^ filt_net_i[idx]) & filt_mask_i[idx]) == '0);
        return general_disable_i || (disable_vec_i[idx] == REL_DISABLED) || !ip_ok;
    endfunction

    // Refuse new frames while stopped or halted
    assign req_ready_o = (state == ST_IDLE) && !cpu_stop_i && !bkpt_halt_i;
    assign take        = req_valid_i && req_ready_o;

    assign is_rw    = (q_fc == FC_RD_WR);
    assign is_wr    = fc_is_write(q_fc);
    assign req_type = fc_dtype(q_fc);
    assign bcast    = (q_slave == ADDR_BCAST);
    // Own address outside the legal span never matches
    assign addr_ok  = bcast || ((q_slave == own_addr_i) && (own_addr_i >= ADDR_MIN)
                      && (own_addr_i <= ADDR_MAX));
    assign qty_a    = fc_is_single(q_fc) ? LIM_SINGLE : q_qty;
    assign qty_b    = is_rw ? q_wqty : qty_a;
    assign first_a  = {1'b0, q_addr} + 17'h00001;
    assign first_b  = is_rw ? ({1'b0, q_waddr} + 17'h00001) : first_a;

    mbsrc_rel_match #(
        .NUM_REL     (NUM_REL),
        .IDX_W       (IDX_W)
    ) u_match_a (
        .rel_type_i  (rel_type_i),
        .rel_start_i (rel_start_i),
        .rel_size_i  (rel_size_i),
        .req_type_i  (req_type),
        .req_first_i (first_a),
        .req_qty_i   (qty_a),
        .found_o     (found_a),
        .index_o     (idx_a)
    );

    mbsrc_rel_match #(
        .NUM_REL     (NUM_REL),
        .IDX_W       (IDX_W)
    ) u_match_b (
        .rel_type_i  (rel_type_i),
        .rel_start_i (rel_start_i),
        .rel_size_i  (rel_size_i),
        .req_type_i  (req_type),
        .req_first_i (first_b),
        .req_qty_i   (qty_b),
        .found_o     (found_b),
        .index_o     (idx_b)
    );

    // First failing check decides the exception code
    always_comb begin
        exc = EXC_NONE;
        if (!fc_supported(q_fc)) begin
            exc = EXC_ILL_FUNC;
        end else if ((qty_a == '0) || (qty_a > fc_limit(q_fc))
                     || (qty_b == '0) || (qty_b > fc_limit(q_fc))) begin
            exc = EXC_ILL_VALUE;
        end else if (!found_a || !found_b || blocked(idx_a) || blocked(idx_b)) begin
            exc = EXC_ILL_ADDR;
        end else if (is_wr && rel_ro_i[idx_b]) begin
            exc = EXC_ILL_FUNC;
        end
    end

    always_comb begin
        next_state   = state;
        next_q_slave = q_slave;
        next_q_fc    = q_fc;
        next_q_addr  = q_addr;
        next_q_qty   = q_qty;
        next_q_waddr = q_waddr;
        next_q_wqty  = q_wqty;
        next_q_ipchk = q_ipchk;
        next_q_ip    = q_ip;
        next_r_reply = r_reply;
        next_r_serve = r_serve;
        next_r_exc   = r_exc;
        next_r_write = r_write;
        next_r_bit   = r_bit;
        next_r_rel   = r_rel;
        next_r_wrel  = r_wrel;
        next_r_addr  = r_addr;
        next_r_waddr = r_waddr;
        next_r_qty   = r_qty;
        unique case (state)
            ST_IDLE: begin
                if (take) begin
                    next_q_slave = req_slave_i;
                    next_q_fc    = req_fc_i;
                    next_q_addr  = req_addr_i;
                    next_q_qty   = req_qty_i;
                    next_q_waddr = req_waddr_i;
                    next_q_wqty  = req_wqty_i;
                    next_q_ipchk = req_ip_check_i;
                    next_q_ip    = req_ip_i;
                    next_state   = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (cpu_stop_i) begin
                    next_state = ST_IDLE;
                end else if (is_wr && bkpt_halt_i && addr_ok) begin
                    next_state = ST_HOLD;
                end else begin
                    // Foreign or reserved addresses are dropped silently
                    next_r_reply = addr_ok && !bcast;
                    next_r_serve = addr_ok && (exc == EXC_NONE);
                    next_r_exc   = addr_ok ? exc : EXC_NONE;
                    next_r_write = is_wr;
                    next_r_bit   = dtype_is_bit(req_type);
                    next_r_rel   = idx_a;
                    next_r_wrel  = idx_b;
                    // Bit relations rely on counts in whole bytes
                    next_r_addr  = rel_iec_i[idx_a]
                                   + IEC_W'(first_a - rel_start_i[idx_a]);
                    next_r_waddr = rel_iec_i[idx_b]
                                   + IEC_W'(first_b - rel_start_i[idx_b]);
                    next_r_qty   = qty_a;
                    next_state   = ST_RESP;
                end
            end
            ST_HOLD: begin
                // Re-check after release since configuration may have moved
                if (cpu_stop_i) begin
                    next_state = ST_IDLE;
                end else if (!bkpt_halt_i) begin
                    next_state = ST_CHECK;
                end
            end
            ST_RESP: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= ST_IDLE;
            q_slave <= '0;
            q_fc    <= '0;
            q_addr  <= '0;
            q_qty   <= '0;
            q_waddr <= '0;
            q_wqty  <= '0;
            q_ipchk <= 1'b0;
            q_ip    <= '0;
            r_reply <= 1'b0;
            r_serve <= 1'b0;
            r_exc   <= EXC_NONE;
            r_write <= 1'b0;
            r_bit   <= 1'b0;
            r_rel   <= '0;
            r_wrel  <= '0;
            r_addr  <= '0;
            r_waddr <= '0;
            r_qty   <= '0;
        end else begin
            state   <= next_state;
            q_slave <= next_q_slave;
            q_fc    <= next_q_fc;
            q_addr  <= next_q_addr;
            q_qty   <= next_q_qty;
            q_waddr <= next_q_waddr;
            q_wqty  <= next_q_wqty;
            q_ipchk <= next_q_ipchk;
            q_ip    <= next_q_ip;
            r_reply <= next_r_reply;
            r_serve <= next_r_serve;
            r_exc   <= next_r_exc;
            r_write <= next_r_write;
            r_bit   <= next_r_bit;
            r_rel   <= next_r_rel;
            r_wrel  <= next_r_wrel;
            r_addr  <= next_r_addr;
            r_waddr <= next_r_waddr;
            r_qty   <= next_r_qty;
        end
    end

    assign resp_valid_o  = (state == ST_RESP);
    assign resp_reply_o  = r_reply;
    assign resp_serve_o  = r_serve;
    assign resp_exc_o    = r_exc;
    assign resp_write_o  = r_write;
    assign resp_is_bit_o = r_bit;
    assign resp_rel_o    = r_rel;
    assign resp_wrel_o   = r_wrel;
    assign resp_addr_o   = r_addr;
    assign resp_waddr_o  = r_waddr;
    assign resp_qty_o    = r_qty;

    // Relation table is bounded by the server limit
    if (NUM_REL > NUM_REL_MAX) begin : g_too_many
        $error("relation count above server limit");
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    no_ready_stop_a: assert property ((cpu_stop_i || bkpt_halt_i) |-> !req_ready_o)
        else $error("ready while stopped or halted");
    bcast_silent_a: assert property (resp_valid_o && (q_slave == ADDR_BCAST) |-> !resp_reply_o)
        else $error("reply sent to broadcast");
    resv_addr_a: assert property (resp_valid_o && (q_slave > ADDR_MAX)
                                  |-> !resp_reply_o && !resp_serve_o)
        else $error("reserved address answered");
    disabled_rel_a: assert property (resp_valid_o && resp_serve_o
                                     |-> !disable_vec_i[resp_rel_o] && !general_disable_i)
        else $error("disabled relation served");
    ro_write_a: assert property (resp_valid_o && resp_serve_o && resp_write_o
                                 |-> !rel_ro_i[resp_wrel_o])
        else $error("write served on read-only relation");
    unsup_fc_a: assert property (resp_valid_o && resp_reply_o && !fc_supported(q_fc)
                                 |-> resp_exc_o == EXC_ILL_FUNC)
        else $error("unsupported function not refused");
    qty_limit_a: assert property (resp_valid_o && resp_serve_o
                                  |-> (resp_qty_o != '0) && (resp_qty_o <= fc_limit(q_fc)))
        else $error("quantity over limit served");
    // Checked in the cycle where an unheld write would answer
    bkpt_hold_a: assert property (take && fc_is_write(req_fc_i)
                                  && (req_slave_i == own_addr_i) && (own_addr_i >= ADDR_MIN)
                                  && (own_addr_i <= ADDR_MAX)
                                  ##1 bkpt_halt_i[*2] |-> !resp_valid_o)
        else $error("write completed during breakpoint");
    bit_map_a: assert property (resp_valid_o && resp_serve_o
                                |-> resp_is_bit_o == dtype_is_bit(rel_type_i[resp_rel_o]))
        else $error("mapping kind mismatch");
    resp_time_a: assert property (take ##1 (!bkpt_halt_i && !cpu_stop_i) |=> resp_valid_o)
        else $error("response not produced in time");

    served_read_c: cover property (resp_valid_o && resp_serve_o && !resp_write_o);
    served_write_c: cover property (resp_valid_o && resp_serve_o && resp_write_o);
    exception_c: cover property (resp_valid_o && resp_reply_o && (resp_exc_o != EXC_NONE));
    hold_c: cover property (state == ST_HOLD ##1 state == ST_CHECK);
endmodule // mbsrc_checker

// >>> hw/mbsrc_pkg.sv
// Summary of operation
// - Accept broadcast address zero and own address
// - Own address valid 1 to 247 only
// - Disable bit 1 blocks its relation
// - No communication while stopped or at breakpoint; an accepted read still answers at breakpoint
// - Four data types, coil by default
// - Start 1 to 65536, count 1 to 65536
// - Read-only relation refuses write functions
// - Whole range must sit inside one relation
// - Read limits 2000 bits, 125 registers; 121 registers for the combined read/write function
// - Write limits 1, 1968, 123, 121 items
// - Only the ten listed function codes supported
// - Breakpoint halts at first attempted write
// - At most 32 server relations
// - General or per-relation bit disables relations
// - Client IP must match network under mask
package mbsrc_pkg;
    localparam int          NUM_REL_MAX   = 32;
    localparam int          ADDR_W        = 17;
    localparam int          QTY_W         = 16;
    localparam int          IEC_W         = 32;
    localparam int          IP_W          = 32;
    localparam logic [7:0]  ADDR_BCAST    = 8'h00;
    localparam logic [7:0]  ADDR_MIN      = 8'h01;
    localparam logic [7:0]  ADDR_MAX      = 8'hf7;
    localparam logic        REL_DISABLED  = 1'b1;
    localparam logic [7:0]  FC_RD_COILS   = 8'h01;
    localparam logic [7:0]  FC_RD_INSTAT  = 8'h02;
    localparam logic [7:0]  FC_RD_HOLD    = 8'h03;
    localparam logic [7:0]  FC_RD_INREG   = 8'h04;
    localparam logic [7:0]  FC_WR_COIL    = 8'h05;
    localparam logic [7:0]  FC_WR_REG     = 8'h06;
    localparam logic [7:0]  FC_WR_COILS   = 8'h0f;
    localparam logic [7:0]  FC_WR_REGS    = 8'h10;
    localparam logic [7:0]  FC_MASK_WR    = 8'h16;
    localparam logic [7:0]  FC_RD_WR      = 8'h17;
    localparam logic [15:0] LIM_RD_BITS   = 16'h07d0;
    localparam logic [15:0] LIM_RD_REGS   = 16'h007d;
    localparam logic [15:0] LIM_SINGLE    = 16'h0001;
    localparam logic [15:0] LIM_WR_COILS  = 16'h07b0;
    localparam logic [15:0] LIM_WR_REGS   = 16'h007b;
    localparam logic [15:0] LIM_RW        = 16'h0079;
    localparam logic [7:0]  EXC_NONE      = 8'h00;
    localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
    localparam logic [7:0]  EXC_ILL_VALUE = 8'h03;

    typedef enum logic [1:0] {
        DT_COIL   = 2'h0,
        DT_INSTAT = 2'h1,
        DT_HOLD   = 2'h2,
        DT_INREG  = 2'h3
    } mbsrc_dtype_t;

    function automatic logic fc_supported(input logic [7:0] fc);
        return fc inside {FC_RD_COILS, FC_RD_INSTAT, FC_RD_HOLD, FC_RD_INREG, FC_WR_COIL,
                          FC_WR_REG, FC_WR_COILS, FC_WR_REGS, FC_MASK_WR, FC_RD_WR};
    endfunction

    function automatic logic fc_is_write(input logic [7:0] fc);
        return fc inside {FC_WR_COIL, FC_WR_REG, FC_WR_COILS, FC_WR_REGS, FC_MASK_WR, FC_RD_WR};
    endfunction

    function automatic logic fc_is_single(input logic [7:0] fc);
        return fc inside {FC_WR_COIL, FC_WR_REG, FC_MASK_WR};
    endfunction

    function automatic mbsrc_dtype_t fc_dtype(input logic [7:0] fc);
        if (fc == FC_RD_INSTAT) begin
            return DT_INSTAT;
        end else if (fc == FC_RD_INREG) begin
            return DT_INREG;
        end else if (fc inside {FC_RD_HOLD, FC_WR_REG, FC_WR_REGS, FC_MASK_WR, FC_RD_WR}) begin
            return DT_HOLD;
        end
        return DT_COIL;
    endfunction

    function automatic logic [15:0] fc_limit(input logic [7:0] fc);
        if (fc inside {FC_RD_COILS, FC_RD_INSTAT}) begin
            return LIM_RD_BITS;
        end else if (fc inside {FC_RD_HOLD, FC_RD_INREG}) begin
            return LIM_RD_REGS;
        end else if (fc == FC_WR_COILS) begin
            return LIM_WR_COILS;
        end else if (fc == FC_WR_REGS) begin
            return LIM_WR_REGS;
        end else if (fc == FC_RD_WR) begin
            return LIM_RW;
        end
        return LIM_SINGLE;
    endfunction

    function automatic logic dtype_is_bit(input mbsrc_dtype_t t);
        return (t == DT_COIL) || (t == DT_INSTAT);
    endfunction
endpackage

// >>> hw/mbsrc_rel_match.sv
`timescale 1ns/1ps
module mbsrc_rel_match #(
    parameter int NUM_REL = 32,
    parameter int IDX_W   = 5
) (
    input  wire mbsrc_pkg::mbsrc_dtype_t [NUM_REL-1:0]        rel_type_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::ADDR_W-1:0]    rel_start_i,
    input  wire logic [NUM_REL-1:0][mbsrc_pkg::ADDR_W-1:0]    rel_size_i,
    input  wire mbsrc_pkg::mbsrc_dtype_t                      req_type_i,
    input  wire logic [mbsrc_pkg::ADDR_W-1:0]                 req_first_i,
    input  wire logic [mbsrc_pkg::QTY_W-1:0]                  req_qty_i,
    output logic                                              found_o,
    output logic [IDX_W-1:0]                                  index_o
);
    import mbsrc_pkg::*;

    logic [NUM_REL-1:0] hit;
    logic [ADDR_W:0]    req_end;

    assign req_end = {1'b0, req_first_i} + {2'b00, req_qty_i};

    // Both ends checked so a range cannot straddle two relations
    for (genvar i = 0; i < NUM_REL; i++) begin : g_rel
        logic [ADDR_W:0] rel_end;
        assign rel_end = {1'b0, rel_start_i[i]} + {1'b0, rel_size_i[i]};
        assign hit[i]  = (rel_type_i[i] == req_type_i) && (req_first_i >= rel_start_i[i])
                         && (req_end <= rel_end);
    end

    // Lowest relation wins when configurations overlap
    always_comb begin
        found_o = 1'b0;
        index_o = '0;
        for (int i = NUM_REL - 1; i >= 0; i--) begin
            if (hit[i]) begin
                found_o = 1'b1;
                index_o = IDX_W'(i);
            end
        end
    end
endmodule // mbsrc_rel_match

// >>> dv/mbsrc_master_model.sv
`timescale 1ns/1ps
module mbsrc_master_model (
    input  wire logic        clk_i,
    input  wire logic        ready_i,
    input  wire logic        resp_valid_i,
    output logic             valid_o,
    output logic [7:0]       slave_o,
    output logic [7:0]       fc_o,
    output logic [15:0]      addr_o,
    output logic [15:0]      qty_o
);
    initial begin
        {valid_o, slave_o, fc_o, addr_o, qty_o} = '0;
    end

    // Request held until the edge that takes it
    task automatic issue(input logic [7:0] sl, f, input logic [15:0] a, q);
        @(posedge clk_i);
        valid_o <= 1'b1;
        {slave_o, fc_o, addr_o, qty_o} <= {sl, f, a, q};
        repeat (50) begin
            @(posedge clk_i);
            if (ready_i) break;
        end
        valid_o <= 1'b0;
        // Released fields toggle so stale values cannot pass
        {slave_o, fc_o, addr_o, qty_o} <= ~{sl, f, a, q};
    endtask

    task automatic await_resp(output int n);
        for (n = 1; n < 60; n++) begin
            @(posedge clk_i);
            if (resp_valid_i) break;
        end
    endtask
endmodule // mbsrc_master_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import mbsrc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, stop = 1'b0, bkpt = 1'b0, gdis = 1'b0, ipc = 1'b1;
    logic [7:0] own = 8'h11, rexc, msl, mfc;
    logic [31:0] dis, ro = '0, raddr, ip = 32'hc0a80105;
    mbsrc_dtype_t [31:0] rtype;
    logic [31:0][16:0] rstart, rsize;
    logic [31:0][31:0] iec, fnet, fmask;
    logic mv, rdy, rv, rrep, rsrv, rwr, rbit;
    logic wsep = 1'b0;
    logic [15:0] mad, mq, wad, wq, rq;
    logic [4:0] rrel, rwrel;
    logic [31:0] rwa;
    int n_errors = 0, checks_done = 0, lat;

    always #5 clk = ~clk;

    mbsrc_master_model i_m (.clk_i(clk), .ready_i(rdy), .resp_valid_i(rv), .valid_o(mv),
        .slave_o(msl), .fc_o(mfc), .addr_o(mad), .qty_o(mq));

    mbsrc_checker i_dut (.clk_i(clk), .rst_i(rst), .own_addr_i(own), .cpu_stop_i(stop),
        .bkpt_halt_i(bkpt), .general_disable_i(gdis), .disable_vec_i(dis), .rel_type_i(rtype),
        .rel_start_i(rstart), .rel_size_i(rsize), .rel_ro_i(ro), .rel_iec_i(iec),
        .filt_net_i(fnet), .filt_mask_i(fmask), .req_valid_i(mv), .req_ready_o(rdy),
        .req_slave_i(msl), .req_fc_i(mfc), .req_addr_i(mad), .req_qty_i(mq),
        .req_waddr_i(wsep ? wad : mad), .req_wqty_i(wsep ? wq : mq), .req_ip_check_i(ipc),
        .req_ip_i(ip), .resp_valid_o(rv), .resp_reply_o(rrep), .resp_serve_o(rsrv),
        .resp_exc_o(rexc), .resp_write_o(rwr), .resp_is_bit_o(rbit), .resp_rel_o(rrel),
        .resp_wrel_o(rwrel), .resp_addr_o(raddr), .resp_waddr_o(rwa), .resp_qty_o(rq));

    task automatic chk(input string what, input logic [31:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic req(input logic [7:0] sl, f, input logic [15:0] a, q,
                       input logic r, s, input logic [7:0] e);
        i_m.issue(sl, f, a, q);
        i_m.await_resp(lat);
        chk("latency", 2, lat);
        chk("reply", r, rrep);
        chk("serve", s, rsrv);
        chk("exception", e, rexc);
    endtask

    task automatic t_codes();
        logic [7:0] fc [12] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10,
                                8'h16, 8'h17, 8'h07, 8'h18};
        logic [31:0] ea [10] = '{32'h102, 32'h100a, 32'h4a, 32'h8a, 32'h102, 32'h4a,
                                 32'h102, 32'h4a, 32'h4a, 32'h4a};
        int rl [10] = '{0, 1, 2, 3, 0, 2, 0, 2, 2, 2};
        for (int i = 0; i < 12; i++) begin
            if (i < 10) begin
                req(own, fc[i], 16'h000a, 16'h0008, 1'b1, 1'b1, EXC_NONE);
                chk("addr", ea[i], raddr);
                chk("is_bit", fc[i] inside {8'h01, 8'h02, 8'h05, 8'h0f}, rbit);
                chk("write", i > 3, rwr);
                chk("rel", rl[i], rrel);
                chk("wrel", rl[i], rwrel);
                chk("waddr", ea[i], rwa);
                chk("qty", fc[i] inside {8'h05, 8'h06, 8'h16} ? 1 : 8, rq);
            end else begin
                req(own, fc[i], 16'h000a, 16'h0008, 1'b1, 1'b0, EXC_ILL_FUNC);
            end
        end
    endtask

    task automatic t_limits();
        logic [7:0] fc [12] = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h0f, 8'h0f, 8'h10,
                                8'h10, 8'h17, 8'h17, 8'h02};
        logic [15:0] q [12] = '{16'h07d0, 16'h07d1, 16'h0000, 16'h007d, 16'h007e, 16'h07b0,
                                16'h07b1, 16'h007b, 16'h007c, 16'h0079, 16'h007a, 16'h07d1};
        for (int i = 0; i < 12; i++) begin
            req(own, fc[i], 16'h000a, q[i], 1'b1, i inside {0, 3, 5, 7, 9},
                i inside {0, 3, 5, 7, 9} ? EXC_NONE : EXC_ILL_VALUE);
        end
    endtask

    task automatic t_range();
        req(own, 8'h03, 16'h00be, 16'h000a, 1'b1, 1'b1, EXC_NONE);
        req(own, 8'h03, 16'h00be, 16'h000b, 1'b1, 1'b0, EXC_ILL_ADDR);
        req(own, 8'h01, 16'h0007, 16'h0008, 1'b1, 1'b0, EXC_ILL_ADDR);
    endtask

    // Write part of the combined function given its own range
    task automatic t_pair();
        wsep <= 1'b1;
        {wad, wq} <= {16'h0063, 16'h0004};
        req(own, 8'h17, 16'h000a, 16'h0008, 1'b1, 1'b1, EXC_NONE);
        chk("waddr", 32'ha3, rwa);
        chk("wrel", 2, rwrel);
        {wad, wq} <= {16'h00c7, 16'h0002};
        req(own, 8'h17, 16'h000a, 16'h0008, 1'b1, 1'b0, EXC_ILL_ADDR);
        {wad, wq} <= {16'h0063, 16'h007a};
        req(own, 8'h17, 16'h000a, 16'h0008, 1'b1, 1'b0, EXC_ILL_VALUE);
        wsep <= 1'b0;
    endtask

    task automatic t_access();
        ro[2] <= 1'b1;
        req(own, 8'h06, 16'h000a, 16'h0001, 1'b1, 1'b0, EXC_ILL_FUNC);
        req(own, 8'h03, 16'h000a, 16'h0001, 1'b1, 1'b1, EXC_NONE);
        ro[2] <= 1'b0;
        dis[2] <= 1'b1;
        req(own, 8'h03, 16'h000a, 16'h0001, 1'b1, 1'b0, EXC_ILL_ADDR);
        dis[2] <= 1'b0;
        gdis <= 1'b1;
        req(own, 8'h01, 16'h000a, 16'h0008, 1'b1, 1'b0, EXC_ILL_ADDR);
        gdis <= 1'b0;
        ip <= 32'hc0a80205;
        req(own, 8'h03, 16'h000a, 16'h0001, 1'b1, 1'b0, EXC_ILL_ADDR);
        ip <= 32'hc0a80105;
    endtask

    task automatic t_addr();
        req(8'h00, 8'h06, 16'h000a, 16'h0001, 1'b0, 1'b1, EXC_NONE);
        req(8'h12, 8'h03, 16'h000a, 16'h0001, 1'b0, 1'b0, EXC_NONE);
        own <= 8'hf8;
        req(8'hf8, 8'h03, 16'h000a, 16'h0001, 1'b0, 1'b0, EXC_NONE);
        own <= 8'h11;
    endtask

    task automatic t_halt();
        int seen = 0;
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        chk("ready", 1'b0, rdy);
        stop <= 1'b0;
        i_m.issue(own, 8'h06, 16'h000a, 16'h0001);
        bkpt <= 1'b1;
        repeat (8) begin
            @(posedge clk);
            seen += int'(rv !== 1'b0);
        end
        chk("held", 0, seen);
        chk("ready", 1'b0, rdy);
        bkpt <= 1'b0;
        i_m.await_resp(lat);
        chk("latency", 3, lat);
        chk("serve", 1'b1, rsrv);
    endtask

    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        dis = 32'hffff_fff0;
        for (int i = 0; i < 32; i++) begin
            rtype[i] = DT_INREG;
            {rstart[i], rsize[i]} = {17'h10000, 17'h00001};
            {iec[i], fnet[i], fmask[i]} = '0;
        end
        // Bit relations sized in whole bytes
        rtype[0] = DT_COIL;
        rtype[1] = DT_INSTAT;
        rtype[2] = DT_HOLD;
        rtype[3] = DT_INREG;
        {rstart[0], rsize[0], iec[0]} = {17'h9, 17'h800, 32'h100};
        {rstart[1], rsize[1], iec[1]} = {17'h1, 17'h800, 32'h1000};
        {rstart[2], rsize[2], iec[2]} = {17'h1, 17'hc8, 32'h40};
        {rstart[3], rsize[3], iec[3]} = {17'h1, 17'hc8, 32'h80};
        {fnet[2], fmask[2]} = {32'hc0a80100, 32'hffffff00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("ready", 1'b1, rdy);
        t_codes();
        t_limits();
        t_range();
        t_pair();
        t_access();
        t_addr();
        t_halt();
        results();
    end

    initial begin
        #400000;
        n_errors++;
        results();
    end
endmodule // tb_top
